/* File: logic/jsdr_top.sv */
// Test data registers, TAP controller and debug mailbox of the JTAG port
`timescale 1ns/1ps
module jsdr_top #(
    parameter logic [3:0] ID_VERSION = 4'h0,
    parameter logic [15:0] ID_PART = 16'h0000,
    parameter logic [10:0] ID_MAKER = 11'h000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOe,
    input wire logic tapEnableFuse,
    input wire logic tapDisableBit,
    input wire logic lockBitOne,
    input wire logic lockBitTwo,
    input wire logic [1:0] clkOptFuse,
    input wire logic extResetN,
    input wire logic cpuWrEn,
    input wire logic cpuRdEn,
    input wire logic [7:0] cpuWrData,
    output logic [7:0] cpuRdData,
    output logic ioFallback,
    input wire logic [jsdr_pkg::NPINS-1:0] pinIn,
    input wire jsdr_pkg::jsdr_pad_t coreDrive,
    output jsdr_pkg::jsdr_pad_t padDrive,
    output logic chipReset,
    output logic debugEnableFuse,
    output logic [3:0] privSel
);
    import jsdr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Crossings into the test clock domain

    jsdr_tck_t t_r;
    jsdr_tck_t t_nxt;
    jsdr_clk_t c_r;
    jsdr_clk_t c_nxt;
    logic tdo_r;
    logic tdoOe_r;

    logic [20:0] toTck;
    logic [20:0] inTck;
    logic tRst;
    logic tTapEn;
    logic tLock;
    logic tExtRstN;
    logic tDirty;
    logic [7:0] tMbx;
    logic [NPINS-1:0] tPin;

    // Pins, straps and mailbox levels, each through two flops
    assign toTck = {rst, tapEnableFuse & ~tapDisableBit,
        lockBitOne | lockBitTwo, extResetN, c_r.dirty, c_r.mbxByte, pinIn};

    jsdr_sync #(.W(21)) syncTck (
        .clk(tck),
        .din(toTck),
        .dout(inTck)
    );

    assign tRst = inTck[20];
    assign tTapEn = inTck[19];
    assign tLock = inTck[18];
    assign tExtRstN = inTck[17];
    assign tDirty = inTck[16];
    assign tMbx = inTck[15:8];
    assign tPin = inTck[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Boundary cells and pad multiplexer

    logic [BSC_W-1:0] bscCap;
    logic extestOn;

    assign extestOn = (t_r.ir == OP_EXTEST);
    assign bscCap[BSC_W-1] = tExtRstN; // Observe-only reset cell

    // Per pin: data cell observes the pin, control cell its latch
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : gPin
            assign bscCap[2*gi] = tPin[gi];
            assign bscCap[2*gi+1] = t_r.bscLatch[2*gi+1];
            assign padDrive.dat[gi] = extestOn ? t_r.bscLatch[2*gi]
                : c_r.core.dat[gi];
            assign padDrive.oe[gi] = extestOn ? t_r.bscLatch[2*gi+1]
                : c_r.core.oe[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // TAP controller and data registers on the test clock

    logic [31:0] capVal;
    logic [31:0] shifted;
    int drLen;
    logic fuseAllowed;

    assign fuseAllowed = ~tLock | t_r.erased;

    // Capture value and length of the register the instruction selects
    always_comb begin
        capVal = 32'h0;
        drLen = LEN_ONE;
        case (t_r.ir)
            OP_IDCODE: begin
                capVal = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
                drLen = LEN_ID;
            end
            OP_EXTEST, OP_SAMPLE: begin
                capVal = {{(32-BSC_W){1'b0}}, bscCap};
                drLen = BSC_W;
            end
            OP_DBG_MBX: begin
                capVal = {23'h0, tDirty, tMbx};
                drLen = LEN_MBX;
            end
            OP_DBG_ACC: begin
                capVal = {31'h0, t_r.accessEn};
            end
            OP_PROG: begin
                capVal = {30'h0, t_r.erased, t_r.debugFuse};
                drLen = LEN_PROG;
            end
            default: begin
                capVal = 32'h0;
            end
        endcase
    end

    assign shifted = {1'b0, t_r.drShift[31:1]};

    // Next state, TMS sampled on the rising test clock edge
    always_comb begin
        t_nxt = t_r;
        case (t_r.tap)
            TAP_TLR: t_nxt.tap = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: t_nxt.tap = tms ? TAP_SELDR : TAP_RTI;
            TAP_SELDR: t_nxt.tap = tms ? TAP_SELIR : TAP_CAPDR;
            TAP_CAPDR: t_nxt.tap = tms ? TAP_EX1DR : TAP_SHDR;
            TAP_SHDR: t_nxt.tap = tms ? TAP_EX1DR : TAP_SHDR;
            TAP_EX1DR: t_nxt.tap = tms ? TAP_UDR : TAP_PDR;
            TAP_PDR: t_nxt.tap = tms ? TAP_EX2DR : TAP_PDR;
            TAP_EX2DR: t_nxt.tap = tms ? TAP_UDR : TAP_SHDR;
            TAP_UDR: t_nxt.tap = tms ? TAP_SELDR : TAP_RTI;
            TAP_SELIR: t_nxt.tap = tms ? TAP_TLR : TAP_CAPIR;
            TAP_CAPIR: t_nxt.tap = tms ? TAP_EX1IR : TAP_SHIR;
            TAP_SHIR: t_nxt.tap = tms ? TAP_EX1IR : TAP_SHIR;
            TAP_EX1IR: t_nxt.tap = tms ? TAP_UIR : TAP_PIR;
            TAP_PIR: t_nxt.tap = tms ? TAP_EX2IR : TAP_PIR;
            TAP_EX2IR: t_nxt.tap = tms ? TAP_UIR : TAP_SHIR;
            TAP_UIR: t_nxt.tap = tms ? TAP_SELDR : TAP_RTI;
            default: t_nxt.tap = TAP_TLR;
        endcase
        case (t_r.tap)
            TAP_TLR: begin
                t_nxt.ir = OP_IDCODE;
                t_nxt.privSel = 4'h0;
            end
            TAP_CAPIR: begin
                t_nxt.irShift = IR_CAPTURE;
            end
            TAP_SHIR: begin
                t_nxt.irShift = {tdi, t_r.irShift[3:1]};
            end
            TAP_UIR: begin
                t_nxt.ir = t_r.irShift;
                // Private debug opcodes only for an unlocked debug part
                for (int i = 0; i < 4; i++) begin
                    t_nxt.privSel[i] = (t_r.irShift == (OP_DBG_MBX
                        + 4'(i))) & t_r.debugFuse & ~tLock;
                end
            end
            TAP_CAPDR: begin
                t_nxt.drShift = capVal;
            end
            TAP_SHDR: begin
                // Serial input enters at the top of the selected length
                for (int i = 0; i < 32; i++) begin
                    if (i == drLen - 1) begin
                        t_nxt.drShift[i] = tdi;
                    end else if (i < drLen - 1) begin
                        t_nxt.drShift[i] = shifted[i];
                    end else begin
                        t_nxt.drShift[i] = 1'b0;
                    end
                end
                if (t_r.ir == OP_SCAN_RST) begin
                    t_nxt.resetDr = tdi;
                end
            end
            TAP_UDR: begin
                case (t_r.ir)
                    OP_EXTEST, OP_SAMPLE: begin
                        t_nxt.bscLatch = t_r.drShift[BSC_W-1:0];
                    end
                    OP_DBG_MBX: begin
                        t_nxt.clrTog = ~t_r.clrTog;
                    end
                    OP_DBG_ACC: begin
                        t_nxt.accessEn = t_r.drShift[0];
                    end
                    OP_PROG: begin
                        if (t_r.drShift[1]) begin
                            t_nxt.erased = 1'b1;
                        end
                        if (fuseAllowed) begin
                            t_nxt.debugFuse = t_r.drShift[0];
                        end
                    end
                    default: begin
                        t_nxt.erased = t_r.erased;
                    end
                endcase
            end
            default: begin
                t_nxt.ir = t_r.ir;
            end
        endcase
    end

    // A disabled port holds the controller in Test-Logic-Reset
    always_ff @(posedge tck) begin
        if (tRst || !tTapEn) begin
            t_r <= TCK_INIT;
        end else begin
            t_r <= t_nxt;
        end
    end

    // Serial output changes on the falling test clock edge
    always_ff @(negedge tck) begin
        if (tRst || !tTapEn) begin
            tdo_r <= 1'b0;
            tdoOe_r <= 1'b0;
        end else begin
            tdoOe_r <= (t_r.tap == TAP_SHDR) || (t_r.tap == TAP_SHIR);
            if (t_r.tap == TAP_SHIR) begin
                tdo_r <= t_r.irShift[0];
            end else if (t_r.ir == OP_SCAN_RST) begin
                tdo_r <= t_r.resetDr;
            end else begin
                tdo_r <= t_r.drShift[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Chip clock side: mailbox, reset sequencing, core pad drive

    logic [6:0] toClk;
    logic [6:0] inClk;
    logic [1:0] cOpt;
    logic cExtRstN;
    logic cResetDr;
    logic cAccess;
    logic cFuse;
    logic cClrTog;
    logic mbxSel;
    logic rstAsk;
    logic [10:0] tout;

    // Test clock levels and pins reach the chip clock through two flops
    assign toClk = {clkOptFuse, extResetN, t_r.resetDr, t_r.accessEn,
        t_r.debugFuse, t_r.clrTog};

    jsdr_sync #(.W(7)) syncClk (
        .clk(clk),
        .din(toClk),
        .dout(inClk)
    );

    assign cOpt = inClk[6:5];
    assign cExtRstN = inClk[4];
    assign cResetDr = inClk[3];
    assign cAccess = inClk[2];
    assign cFuse = inClk[1];
    assign cClrTog = inClk[0];

    assign mbxSel = cFuse & cAccess;
    assign rstAsk = !cExtRstN || cResetDr;

    // Time-out chosen by the clock option fuses
    always_comb begin
        case (cOpt)
            2'h0: tout = RST_TOUT_0;
            2'h1: tout = RST_TOUT_1;
            2'h2: tout = RST_TOUT_2;
            default: tout = RST_TOUT_3;
        endcase
    end

    // Mailbox flag: a CPU write wins over a debugger clear
    always_comb begin
        c_nxt = c_r;
        c_nxt.ioFallback = (cpuWrEn || cpuRdEn) && !mbxSel;
        c_nxt.clrSeen = cClrTog;
        if (cClrTog != c_r.clrSeen) begin
            c_nxt.dirty = 1'b0;
        end
        if (cpuWrEn && mbxSel) begin
            c_nxt.mbxByte = cpuWrData;
            c_nxt.dirty = 1'b1;
        end
        if (cpuRdEn && mbxSel) begin
            c_nxt.rdData = {c_r.dirty, c_r.mbxByte[6:0]};
        end
        if (rstAsk) begin
            c_nxt.rstCnt = tout;
        end else if (c_r.rstCnt != 11'h000) begin
            c_nxt.rstCnt = c_r.rstCnt - 11'h001;
        end
        c_nxt.chipReset = rstAsk || (c_r.rstCnt != 11'h000);
        if (c_nxt.chipReset) begin
            c_nxt.core = '0;
        end else begin
            c_nxt.core = coreDrive;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            c_r <= '{rstCnt: RST_TOUT_0, chipReset: 1'b1, default: '0};
        end else begin
            c_r <= c_nxt;
        end
    end

    assign tdo = tdo_r;
    assign tdoOe = tdoOe_r;
    assign cpuRdData = c_r.rdData;
    assign ioFallback = c_r.ioFallback;
    assign chipReset = c_r.chipReset;
    assign debugEnableFuse = t_r.debugFuse;
    assign privSel = t_r.privSel;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence mbxWrite;
        cpuWrEn && mbxSel;
    endsequence

    sequence rstRelease;
        !rstAsk ##1 !rstAsk;
    endsequence

    ir_default_a: assert property (@(posedge tck)
        (tTapEn && t_r.tap == TAP_TLR && !tRst) |=> t_r.ir == OP_IDCODE)
        else $error("instruction not IDCODE after reset state");

    tap_off_a: assert property (@(posedge tck)
        !tTapEn |=> t_r.tap == TAP_TLR && !t_r.resetDr)
        else $error("disabled port left reset state");

    bypass_zero_a: assert property (@(posedge tck) disable iff (tRst)
        (tTapEn && t_r.tap == TAP_CAPDR && t_r.ir == OP_BYPASS)
        |=> t_r.drShift[0] == 1'b0)
        else $error("bypass stage not cleared on capture");

    fuse_lock_a: assert property (@(posedge tck) disable iff (tRst)
        (tLock && !t_r.erased && !t_r.debugFuse)
        |=> !t_r.debugFuse)
        else $error("debug fuse set on locked part");

    id_shift_a: assert property (@(posedge tck) disable iff (tRst)
        (tTapEn && t_r.tap == TAP_CAPDR && t_r.ir == OP_IDCODE)
        |=> t_r.drShift[0] && t_r.drShift[31:28] == ID_VERSION)
        else $error("identification value captured wrongly");

    mbx_write_a: assert property (@(posedge clk) disable iff (rst)
        mbxWrite |=> c_r.dirty && c_r.mbxByte == $past(cpuWrData))
        else $error("mailbox write lost");

    mbx_overwrite_a: assert property (@(posedge clk) disable iff (rst)
        (c_r.dirty ##0 mbxWrite) |=> c_r.dirty [*1])
        else $error("dirty flag dropped on overwrite");

    mbx_read_a: assert property (@(posedge clk) disable iff (rst)
        (cpuRdEn && mbxSel) |=> cpuRdData ==
        {$past(c_r.dirty), $past(c_r.mbxByte[6:0])})
        else $error("mailbox read layout wrong");

    io_route_a: assert property (@(posedge clk) disable iff (rst)
        (cpuWrEn && !mbxSel) |=> ioFallback &&
        c_r.mbxByte == $past(c_r.mbxByte))
        else $error("access reached mailbox while not enabled");

    reset_hold_a: assert property (@(posedge clk) disable iff (rst)
        cResetDr |=> chipReset && padDrive.oe == '0 || extestOn)
        else $error("reset register one not holding reset");

    reset_tout_a: assert property (@(posedge clk) disable iff (rst)
        ($fell(rstAsk) ##0 rstRelease) |-> $past(chipReset)
        ##0 chipReset)
        else $error("reset released before time-out");

    extest_pads_a: assert property (@(posedge tck) disable iff (tRst)
        extestOn |-> padDrive.oe[0] == t_r.bscLatch[1])
        else $error("EXTEST not driving boundary latches");

endmodule

/* File: logic/jsdr_pkg.sv */
// Constants, state layouts and carriers for the JTAG scan data registers
package jsdr_pkg;

    localparam int NPINS = 8;
    localparam int BSC_W = 2 * NPINS + 1;

    // Instruction opcodes
    localparam logic [3:0] OP_EXTEST = 4'h0;
    localparam logic [3:0] OP_IDCODE = 4'h1;
    localparam logic [3:0] OP_SAMPLE = 4'h2;
    localparam logic [3:0] OP_PROG = 4'h4;
    localparam logic [3:0] OP_DBG_MBX = 4'h8;
    localparam logic [3:0] OP_DBG_ACC = 4'h9;
    localparam logic [3:0] OP_DBG_C = 4'ha;
    localparam logic [3:0] OP_DBG_D = 4'hb;
    localparam logic [3:0] OP_SCAN_RST = 4'hc;
    localparam logic [3:0] OP_BYPASS = 4'hf;
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    // Data register lengths
    localparam int LEN_ID = 32'h20;
    localparam int LEN_MBX = 32'h9;
    localparam int LEN_PROG = 32'h2;
    localparam int LEN_ONE = 32'h1;

    // Identification field positions
    localparam int ID_VER_LSB = 32'h1c;
    localparam int ID_PART_LSB = 32'hc;
    localparam int ID_MFR_LSB = 32'h1;

    // Reset time-out per clock option fuse setting, in clk cycles
    localparam logic [10:0] RST_TOUT_0 = 11'h004;
    localparam logic [10:0] RST_TOUT_1 = 11'h010;
    localparam logic [10:0] RST_TOUT_2 = 11'h040;
    localparam logic [10:0] RST_TOUT_3 = 11'h400;

    typedef enum logic [3:0] {
        TAP_EX2DR = 4'h0, TAP_EX1DR = 4'h1, TAP_SHDR = 4'h2, TAP_PDR = 4'h3,
        TAP_SELIR = 4'h4, TAP_UDR = 4'h5, TAP_CAPDR = 4'h6, TAP_SELDR = 4'h7,
        TAP_EX2IR = 4'h8, TAP_EX1IR = 4'h9, TAP_SHIR = 4'ha, TAP_PIR = 4'hb,
        TAP_RTI = 4'hc, TAP_UIR = 4'hd, TAP_CAPIR = 4'he, TAP_TLR = 4'hf
    } jsdr_tap_t;

    // Pad data and enable travel together
    typedef struct packed {
        logic [NPINS-1:0] dat;
        logic [NPINS-1:0] oe;
    } jsdr_pad_t;

    // State on the test clock
    typedef struct packed {
        jsdr_tap_t tap;
        logic [3:0] irShift;
        logic [3:0] ir;
        logic [31:0] drShift;
        logic resetDr;
        logic [BSC_W-1:0] bscLatch;
        logic accessEn;
        logic debugFuse;
        logic erased;
        logic clrTog;
        logic [3:0] privSel;
    } jsdr_tck_t;

    // State on the chip clock
    typedef struct packed {
        logic [7:0] mbxByte;
        logic dirty;
        logic clrSeen;
        logic [7:0] rdData;
        logic ioFallback;
        logic [10:0] rstCnt;
        logic chipReset;
        jsdr_pad_t core;
    } jsdr_clk_t;

    localparam jsdr_tck_t TCK_INIT = '{tap: TAP_TLR, ir: OP_IDCODE,
        default: '0};

endpackage

/* File: logic/jsdr_sync.sv */
// Two-stage synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module jsdr_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } jsdr_sync_t;

    jsdr_sync_t s_r;
    jsdr_sync_t s_nxt;

    // First stage feeds only the second
    always_comb begin
        s_nxt.meta = din;
        s_nxt.stab = s_r.meta;
    end

    always_ff @(posedge clk) begin
        s_r <= s_nxt;
    end

    assign dout = s_r.stab;

endmodule

/* File: verification/jsdr_jtag_model.sv */
// Behavioural external JTAG controller that drives the test port
`timescale 1ns/1ps
module jsdr_jtag_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // Test clock stands still low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One test clock period: set lines after the fall, sample before rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #80;
        o = tdo;
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask

    // Walk the controller with a TMS pattern, first bit first
    task automatic walk(input logic [7:0] seq, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            step(seq[i], tdi, o);
        end
    endtask

    // Five ones reach Test-Logic-Reset, a zero then parks in Run-Test/Idle
    task automatic reset_tap();
        walk(8'h1f, 6);
    endtask

    // Full scan from Run-Test/Idle back to Run-Test/Idle
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
        output logic [31:0] dout);
        logic o;
        dout = '0;
        if (ir) begin
            walk(8'h03, 4);
        end else begin
            walk(8'h01, 3);
        end
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        walk(8'h01, 2);
        tdi = ~tdi; // Released line does not keep its last value
    endtask
endmodule

/* File: verification/jsdr_top_tb_top.sv */
// Self-checking bench for the JTAG scan data registers block
`timescale 1ns/1ps
module jsdr_top_tb_top;
    import jsdr_pkg::*;

    logic clk = 1'b0, rst = 1'b1, tck, tms, tdi, tdo, tdoOe;
    logic clkRun = 1'b1;
    logic tapEnableFuse = 1'b1, tapDisableBit = 1'b0;
    logic lockBitOne = 1'b0, lockBitTwo = 1'b0;
    logic [1:0] clkOptFuse = 2'h2;
    logic extResetN = 1'b1, cpuWrEn = 1'b0, cpuRdEn = 1'b0;
    logic [7:0] cpuWrData = 8'h00, cpuRdData, pinIn = 8'h96;
    logic ioFallback, chipReset, debugEnableFuse, oeSeen;
    logic [3:0] privSel;
    jsdr_pad_t coreDrive = '{dat: 8'h33, oe: 8'hcc}, padDrive;
    logic [31:0] d, pre;
    int errCount = 0, nCompared = 0, k;

    // Chip clock, stoppable to show the scan path needs only the test clock
    always #12.5 if (clkRun) clk = ~clk;

    jsdr_top #(.ID_VERSION(4'h3), .ID_PART(16'h5a5a), .ID_MAKER(11'h2b5))
    jsdr_top_i (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdoOe(tdoOe), .tapEnableFuse(tapEnableFuse),
        .tapDisableBit(tapDisableBit), .lockBitOne(lockBitOne),
        .lockBitTwo(lockBitTwo), .clkOptFuse(clkOptFuse),
        .extResetN(extResetN), .cpuWrEn(cpuWrEn), .cpuRdEn(cpuRdEn),
        .cpuWrData(cpuWrData), .cpuRdData(cpuRdData),
        .ioFallback(ioFallback), .pinIn(pinIn), .coreDrive(coreDrive),
        .padDrive(padDrive), .chipReset(chipReset),
        .debugEnableFuse(debugEnableFuse), .privSel(privSel));

    jsdr_jtag_model jsdr_jtag_model_i (.tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo));

    // Remember whether the port ever drove its serial output
    always @(posedge tck) if (tdoOe === 1'b1) oeSeen <= 1'b1;

    ////////////////////////////////////////////////////////////////////////
    task automatic printVerdict();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic clks(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait for the device reset output to reach a level
    task automatic wait_rst(input logic lvl, output int n);
        n = 0;
        while (chipReset !== lvl && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) begin
            errCount++;
            printVerdict();
        end
    endtask

    // CPU strobes are one cycle wide, driven on the falling edge
    task automatic cpu_wr(input logic [7:0] v, input logic fb);
        @(negedge clk);
        cpuWrEn = 1'b1;
        cpuWrData = v;
        @(negedge clk);
        cpuWrEn = 1'b0;
        check(ioFallback, fb);
    endtask

    task automatic cpu_rd(input logic [7:0] exp);
        @(negedge clk);
        cpuRdEn = 1'b1;
        @(negedge clk);
        cpuRdEn = 1'b0;
        check(cpuRdData, exp);
    endtask

    task automatic ir(input logic [3:0] op);
        jsdr_jtag_model_i.scan(1'b1, op, 4, d);
        check(d, 32'h1);
    endtask

    task automatic dr(input logic [31:0] v, input int n);
        jsdr_jtag_model_i.scan(1'b0, v, n, d);
        clks(6);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_idcode();
        clkRun = 1'b0;
        oeSeen = 1'b0;
        jsdr_jtag_model_i.scan(1'b0, 32'h0, 32, d);
        clkRun = 1'b1;
        check(d, {4'h3, 16'h5a5a, 11'h2b5, 1'b1});
        check(oeSeen, 1'b1);
        ir(4'h5);
        dr(32'h3, 2);
        check(d[0], 1'b0);
        ir(OP_BYPASS);
        dr(32'h3, 2);
        check(d, 32'h2);
        $display("test idcode and bypass done");
    endtask

    task automatic t_lock();
        lockBitOne = 1'b1;
        ir(OP_PROG);
        dr(32'h1, 2);
        check(debugEnableFuse, 1'b0);
        dr(32'h2, 2);
        dr(32'h1, 2);
        check(debugEnableFuse, 1'b1);
        lockBitOne = 1'b0;
        $display("test lock done");
    endtask

    task automatic t_mailbox();
        cpu_wr(8'h11, 1'b1);
        ir(OP_DBG_ACC);
        dr(32'h1, 1);
        cpu_wr(8'ha5, 1'b0);
        cpu_wr(8'h3c, 1'b0);
        cpu_rd(8'hbc);
        ir(OP_DBG_MBX);
        check(privSel, 4'h1);
        dr(32'h0, 9);
        check(d, 32'h13c);
        cpu_rd(8'h3c);
        $display("test mailbox done");
    endtask

    task automatic t_boundary();
        ir(OP_SAMPLE);
        pre = '0;
        for (int i = 0; i < NPINS; i++) begin
            pre[2*i] = d[0] ^ (i % 2 == 1);
            pre[2*i+1] = i >= 4;
        end
        dr(pre, BSC_W);
        for (int i = 0; i < NPINS; i++) begin
            check(d[2*i], pinIn[i]);
        end
        check({16'h0, padDrive}, {16'h0, coreDrive});
        ir(OP_EXTEST);
        clks(4);
        check(padDrive.oe, 8'hf0);
        for (int i = 0; i < NPINS; i++) begin
            check(padDrive.dat[i], pre[2*i]);
        end
        ir(OP_BYPASS);
        $display("test boundary done");
    endtask

    task automatic t_reset();
        ir(OP_SCAN_RST);
        dr(32'h1, 1);
        wait_rst(1'b1, k);
        check(padDrive.oe, 8'h00);
        dr(32'h0, 1);
        check(chipReset, 1'b1);
        wait_rst(1'b0, k);
        check(k + 20 >= 64, 1'b1);
        extResetN = 1'b0;
        clks(8);
        check(chipReset, 1'b1);
        extResetN = 1'b1;
        wait_rst(1'b0, k);
        $display("test reset done");
    endtask

    task automatic t_disable();
        tapDisableBit = 1'b1;
        jsdr_jtag_model_i.reset_tap();
        oeSeen = 1'b0;
        jsdr_jtag_model_i.scan(1'b0, 32'h0, 32, d);
        check({d[31:1], oeSeen}, 32'h0);
        tapDisableBit = 1'b0;
        tapEnableFuse = 1'b0;
        jsdr_jtag_model_i.scan(1'b0, 32'h0, 32, d);
        check({d[31:1], oeSeen}, 32'h0);
        tapEnableFuse = 1'b1;
        jsdr_jtag_model_i.reset_tap();
        $display("test disable done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #7;
        jsdr_jtag_model_i.reset_tap();
        @(negedge clk);
        rst = 1'b0;
        clks(8);
        // Test side leaves its reset only after a few test clock edges
        jsdr_jtag_model_i.reset_tap();
        t_idcode();
        t_lock();
        t_mailbox();
        t_boundary();
        t_reset();
        t_disable();
        printVerdict();
    end
endmodule
